/* File: rtl/idb_params.svh */
/*
  Timing counts and channel layout for the ISA DMA bus signalling block.
  Assumes inclusion by bare name from the rtl folder.
*/
`ifndef IDB_PARAMS_SVH
`define IDB_PARAMS_SVH

`define IDB_CLK_PERIOD_NS 25
// *****************************
// channel layout
// *****************************
`define IDB_NUM_CH 8
`define IDB_CASCADE_CH 4
`define IDB_WIDE_FIRST_CH 5
// *****************************
// flush pulse
// *****************************
`define IDB_FLUSH_NS 50
`define IDB_FLUSH_CYCLES ((`IDB_FLUSH_NS + `IDB_CLK_PERIOD_NS - 1) / `IDB_CLK_PERIOD_NS)
// *****************************
// dma command strobe phases
// *****************************
`define IDB_CMD_SETUP_CYCLES 2
`define IDB_CMD_ACTIVE_CYCLES 4

`endif

/* File: rtl/idb_pkg.sv */
/*
  Types shared by the ISA DMA bus signalling block.
  Assumes nothing of its surroundings.
*/
package idb_pkg;
  typedef enum logic [1:0] {
    IDB_CYC_DMA_READ,
    IDB_CYC_DMA_WRITE,
    IDB_CYC_VERIFY
  } idb_xfer_t;
endpackage

/* File: rtl/idb_local_arb.sv */
/*
  Round-robin arbiter for up to three local bus master requests.
  Assumes requests are active-low and already in the clk_sys domain.
*/
`timescale 1ns/1ps
`include "idb_params.svh"

module idb_local_arb
  import idb_pkg::*;
#(
  parameter int NREQ = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // requests and grants
  input wire logic [NREQ-1:0] req_n,
  input wire logic hold_off,
  output logic [NREQ-1:0] gnt_n
);
  logic [NREQ-1:0] owner;
  logic [NREQ-1:0] last;

  // *****************************
  // pick next winner after last
  // *****************************
  function automatic logic [NREQ-1:0] pick(input logic [NREQ-1:0] req,
                                           input logic [NREQ-1:0] prev);
    logic [NREQ-1:0] win;
    int idx;
    win = '0;
    for (int k = NREQ; k > 0; k--) begin
      for (int j = 0; j < NREQ; j++) begin
        if (prev[j]) begin
          idx = (j + k) % NREQ;
          if (req[idx]) begin
            win = '0;
            win[idx] = 1'b1;
          end
        end
      end
    end
    if (prev == '0) begin
      for (int j = NREQ - 1; j >= 0; j--) begin
        if (req[j]) begin
          win = '0;
          win[j] = 1'b1;
        end
      end
    end
    return win;
  endfunction

  // a grant holds until its request leaves or hold_off clears it; no other preemption here
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      owner <= '0;
      last <= '0;
    end else if (hold_off) begin
      owner <= '0;
    end else if (owner == '0 || (owner & ~req_n) == '0) begin
      owner <= pick(~req_n, last);
      if ((~req_n) != '0) begin
        last <= pick(~req_n, last);
      end
    end
  end

  assign gnt_n = ~owner;
endmodule

/* File: rtl/idb_bus_sig.sv */
/*
  ISA-side signalling of the DMA unit: address enable, terminal count,
  request/acknowledge channels, command strobe direction, low-megabyte
  strobes, turbo/flush pins shared with an extra local master pair.
  Assumes a DMA sequencer supplies cycle ownership and transfer count,
  and that pins are resolved outside from the oe signals.
*/
`timescale 1ns/1ps
`include "idb_params.svh"

module idb_bus_sig
  import idb_pkg::*;
#(
  parameter int NCH = `IDB_NUM_CH,
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // dma sequencer side
  input wire logic dma_start,
  input wire logic [2:0] dma_channel,
  input wire logic [1:0] dma_kind,
  input wire logic [CNT_W-1:0] dma_count,
  input wire logic refresh_run,
  input wire logic dma_hold_ok,
  output logic dma_busy,
  output logic dma_wide,
  // isa channels
  input wire logic [NCH-1:0] dreq,
  output logic [NCH-1:0] dack_n,
  output logic dma_pending,
  output logic aen,
  output logic tc,
  input wire logic master_n,
  input wire logic refresh_in_n,
  output logic refresh_out_n,
  output logic refresh_oe,
  // isa command strobes
  input wire logic memr_in_n,
  input wire logic memw_in_n,
  input wire logic ior_in_n,
  input wire logic iow_in_n,
  output logic memr_out_n,
  output logic memw_out_n,
  output logic ior_out_n,
  output logic iow_out_n,
  output logic mem_cmd_oe,
  output logic io_cmd_oe,
  input wire logic [3:0] addr_hi,
  output logic smemr_n,
  output logic smemw_n,
  output logic io_reg_rd,
  output logic io_reg_wr,
  // shared pins and configuration
  input wire logic cfg_pins_local,
  input wire logic perf_programmed,
  input wire logic flush_enable,
  input wire logic perf_hold,
  input wire logic turbo_or_req_n,
  input wire logic [1:0] local_req_n,
  output logic [1:0] local_gnt_n,
  output logic flush_or_gnt_n,
  output logic slow_mode
);
  // *****************************
  // reset release and pin sync
  // *****************************
  logic [1:0] rst_sync;
  logic rst_n;
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  localparam int NS = 8 + NCH;
  logic [NS-1:0] s1, s2, s3;
  logic [NS-1:0] pins, stable;
  assign pins = {dreq, master_n, turbo_or_req_n, memr_in_n, memw_in_n,
                 ior_in_n, iow_in_n, refresh_in_n, 1'b1};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= {{NCH{1'b0}}, 8'hFF};
      s2 <= {{NCH{1'b0}}, 8'hFF};
      s3 <= {{NCH{1'b0}}, 8'hFF};
      stable <= {{NCH{1'b0}}, 8'hFF};
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < NS; i++) begin
        if (s2[i] == s3[i]) begin
          stable[i] <= s3[i];
        end
      end
    end
  end
  logic [NCH-1:0] dreq_s;
  logic master_s_n, shared_in_s, memr_s_n, memw_s_n, ior_s_n, iow_s_n;
  assign dreq_s = stable[NS-1:8];
  assign master_s_n = stable[7];
  assign shared_in_s = stable[6];
  assign memr_s_n = stable[5];
  assign memw_s_n = stable[4];
  assign ior_s_n = stable[3];
  assign iow_s_n = stable[2];

  // *****************************
  // channel service state
  // *****************************
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_CMD, ST_NEXT} idb_state_t;
  idb_state_t state;
  logic [2:0] chan;
  logic [CNT_W-1:0] remain;
  logic [2:0] phase;
  logic master_cycle;
  idb_xfer_t kind;

  function automatic logic chan_is_wide(input logic [2:0] ch);
    return ch >= 3'(`IDB_WIDE_FIRST_CH);
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      chan <= 3'h0;
      remain <= '0;
      phase <= 3'h0;
      kind <= IDB_CYC_DMA_READ;
    end else begin
      case (state)
        ST_IDLE: begin
          if (dma_start && dma_hold_ok && dma_channel != 3'(`IDB_CASCADE_CH)) begin
            state <= ST_SETUP;
            chan <= dma_channel;
            remain <= dma_count;
            kind <= idb_xfer_t'(dma_kind);
            phase <= 3'h0;
          end
        end
        ST_SETUP: begin
          phase <= phase + 3'h1;
          if (phase == 3'(`IDB_CMD_SETUP_CYCLES - 1)) begin
            state <= ST_CMD;
            phase <= 3'h0;
          end
        end
        ST_CMD: begin
          phase <= phase + 3'h1;
          if (master_cycle) begin
            if (!dreq_s[chan]) begin
              state <= ST_IDLE;
            end
          end else if (phase == 3'(`IDB_CMD_ACTIVE_CYCLES - 1)) begin
            state <= ST_NEXT;
          end
        end
        ST_NEXT: begin
          phase <= 3'h0;
          if (remain == '0 || !dreq_s[chan]) begin
            state <= ST_IDLE;
          end else begin
            remain <= remain - 1'b1;
            state <= ST_SETUP;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // isa master takes over once it pulls master_n low during our grant
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      master_cycle <= 1'b0;
    end else if (state == ST_IDLE) begin
      master_cycle <= 1'b0;
    end else if (!master_s_n) begin
      master_cycle <= 1'b1;
    end
  end

  logic dma_cyc;
  assign dma_cyc = (state != ST_IDLE) && !master_cycle;
  assign dma_busy = state != ST_IDLE;
  assign dma_wide = chan_is_wide(chan);
  assign dma_pending = |(dreq_s & ~(NCH'(1) << `IDB_CASCADE_CH));

  // *****************************
  // bus qualifiers
  // *****************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aen <= 1'b0;
      tc <= 1'b0;
      dack_n <= '1;
      refresh_out_n <= 1'b1;
      refresh_oe <= 1'b0;
    end else begin
      aen <= (dma_cyc || refresh_run) && master_s_n;
      tc <= dma_cyc && state == ST_CMD && remain == '0;
      dack_n <= '1;
      if (state != ST_IDLE) begin
        dack_n[chan] <= 1'b0;
      end
      refresh_out_n <= !(refresh_run && !master_cycle);
      refresh_oe <= refresh_run && !master_cycle;
    end
  end

  // *****************************
  // command strobes
  // *****************************
  logic cmd_on;
  logic [3:0] echo;
  assign cmd_on = dma_cyc && state == ST_CMD;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      memr_out_n <= 1'b1;
      memw_out_n <= 1'b1;
      ior_out_n <= 1'b1;
      iow_out_n <= 1'b1;
      mem_cmd_oe <= 1'b0;
      io_cmd_oe <= 1'b0;
      echo <= 4'h0;
    end else begin
      echo <= {echo[2:0], mem_cmd_oe};
      mem_cmd_oe <= dma_cyc;
      io_cmd_oe <= dma_cyc;
      // read moves memory to the device, write moves device to memory
      memr_out_n <= !(cmd_on && kind == IDB_CYC_DMA_READ);
      iow_out_n <= !(cmd_on && kind == IDB_CYC_DMA_READ);
      memw_out_n <= !(cmd_on && kind == IDB_CYC_DMA_WRITE);
      ior_out_n <= !(cmd_on && kind == IDB_CYC_DMA_WRITE);
    end
  end

  // our drive wins in dma cycles and while the synchroniser still replays it
  logic memr_eff_n, memw_eff_n;
  assign memr_eff_n = (mem_cmd_oe || echo != 4'h0) ? memr_out_n : memr_s_n;
  assign memw_eff_n = (mem_cmd_oe || echo != 4'h0) ? memw_out_n : memw_s_n;
  assign smemr_n = memr_eff_n || (addr_hi != 4'h0);
  assign smemw_n = memw_eff_n || (addr_hi != 4'h0);
  // internal register decode only when not a dma cycle and aen low
  assign io_reg_rd = !io_cmd_oe && echo == 4'h0 && !aen && !ior_s_n;
  assign io_reg_wr = !io_cmd_oe && echo == 4'h0 && !aen && !iow_s_n;

  // *****************************
  // shared turbo / flush pins
  // *****************************
  logic [1:0] flush_cnt;
  logic perf_hold_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      slow_mode <= 1'b0;
      perf_hold_q <= 1'b0;
      flush_cnt <= 2'h0;
    end else begin
      slow_mode <= !cfg_pins_local && perf_programmed && !shared_in_s;
      perf_hold_q <= perf_hold;
      if (!cfg_pins_local && flush_enable && perf_hold && !perf_hold_q) begin
        flush_cnt <= 2'(`IDB_FLUSH_CYCLES);
      end else if (flush_cnt != 2'h0) begin
        flush_cnt <= flush_cnt - 2'h1;
      end
    end
  end

  logic [2:0] lreq_n, lgnt_n;
  assign lreq_n = {cfg_pins_local ? shared_in_s : 1'b1, local_req_n};
  idb_local_arb #(.NREQ(3)) u_arb (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .req_n(lreq_n),
    .hold_off(dma_busy),
    .gnt_n(lgnt_n)
  );
  assign local_gnt_n = lgnt_n[1:0];
  assign flush_or_gnt_n = cfg_pins_local ? lgnt_n[2] : (flush_cnt == 2'h0);

  // *****************************
  // checks
  // *****************************
  sequence s_hold_rise;
    perf_hold && !$past(perf_hold);
  endsequence
  chk_aen_dma_tie: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(dma_cyc) && $past(master_s_n) |-> aen)
    else $error("aen low during dma cycle");
  chk_aen_idle_low: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(dma_cyc) && !$past(refresh_run) |-> !aen)
    else $error("aen high outside dma and refresh");
  chk_tc_last_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
    tc |-> $past(remain) == '0 && $past(state) == ST_CMD)
    else $error("tc outside final cycle");
  chk_dack_onehot: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $countones(~dack_n) <= 1)
    else $error("more than one acknowledge low");
  chk_cmd_dir: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !mem_cmd_oe |-> memr_out_n && memw_out_n ##1 1'b1)
    else $error("memory strobe active while not driven");
  chk_smem_hi: assert property (@(posedge clk_sys) disable iff (!rst_n)
    addr_hi != 4'h0 |-> smemr_n && smemw_n)
    else $error("low megabyte strobe above first megabyte");
  chk_master_aen: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !master_s_n |=> !aen)
    else $error("aen high under isa master");
  chk_turbo_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(perf_programmed) |-> !slow_mode)
    else $error("slow mode before programming");
  chk_flush_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_hold_rise and !cfg_pins_local and flush_enable |=> !flush_or_gnt_n)
    else $error("no flush pulse on performance hold");
  chk_io_decode: assert property (@(posedge clk_sys) disable iff (!rst_n)
    io_cmd_oe |-> !io_reg_rd && !io_reg_wr)
    else $error("internal decode during dma cycle");
endmodule

/* File: bench/idb_isa_side.sv */
/*
  Peripheral side of the ISA bus: one DMA requester and an I/O decoder.
  Assumes command strobes are already resolved from the block's drive.
*/
`timescale 1ns/1ps

module idb_isa_side (
  // clock
  input wire logic clk_sys,
  // request control from the bench
  input wire logic req_on,
  input wire logic [2:0] req_ch,
  // bus as seen by the peripheral
  input wire logic [7:0] dack_n,
  input wire logic tc,
  input wire logic aen,
  input wire logic ior_n,
  input wire logic iow_n,
  output logic [7:0] dreq,
  output int io_hits
);
  logic done = 1'b0;
  logic io_prev = 1'b1;

  initial io_hits = 0;

  // request withdrawn after terminal count, like a floppy controller
  always @(posedge clk_sys) begin
    if (!req_on)
      done <= 1'b0;
    else if (tc && dack_n[req_ch] == 1'b0)
      done <= 1'b1;
  end

  assign dreq = (req_on && !done) ? (8'h01 << req_ch) : 8'h00;

  // no i/o decode while aen is high
  always @(posedge clk_sys) begin
    io_prev <= ior_n & iow_n;
    if (io_prev && !(ior_n & iow_n) && !aen)
      io_hits <= io_hits + 1;
  end
endmodule

/* File: bench/tb_top.sv */
/*
  Self-checking bench for the ISA DMA bus signalling block.
  Assumes the peripheral model in idb_isa_side.sv.
*/
`timescale 1ns/1ps
`include "idb_params.svh"

module tb_top
  import idb_pkg::*;
;
  logic clk_sys = 0, reset_n = 0, dma_start = 0, refresh_run = 0, dma_hold_ok = 1;
  logic [2:0] dma_channel = 0, req_ch = 0;
  logic [1:0] dma_kind = 0, local_req_n = 2'h3, local_gnt_n;
  logic [15:0] dma_count = 0;
  logic master_n = 1, memr_b = 1, memw_b = 1, ior_b = 1, iow_b = 1, req_on = 0;
  logic [3:0] addr_hi = 0;
  logic cfg_pins_local = 0, perf_programmed = 0, flush_enable = 0, perf_hold = 0;
  logic turbo_or_req_n = 1, dma_busy, dma_wide, dma_pending, aen, tc;
  logic [7:0] dreq, dack_n;
  logic refresh_in_n, refresh_out_n, refresh_oe, memr_in_n, memw_in_n, ior_in_n, iow_in_n;
  logic memr_out_n, memw_out_n, ior_out_n, iow_out_n, mem_cmd_oe, io_cmd_oe;
  logic smemr_n, smemw_n, io_reg_rd, io_reg_wr, flush_or_gnt_n, slow_mode;
  int fails = 0, checks = 0, io_hits;

  // pin resolution: our drive wins while enabled
  assign memr_in_n = mem_cmd_oe ? memr_out_n : memr_b;
  assign memw_in_n = mem_cmd_oe ? memw_out_n : memw_b;
  assign ior_in_n = io_cmd_oe ? ior_out_n : ior_b;
  assign iow_in_n = io_cmd_oe ? iow_out_n : iow_b;
  assign refresh_in_n = refresh_oe ? refresh_out_n : 1'b1;

  idb_bus_sig u_idb_bus_sig (.clk_sys, .reset_n, .dma_start, .dma_channel, .dma_kind,
    .dma_count, .refresh_run, .dma_hold_ok, .dma_busy, .dma_wide, .dreq, .dack_n,
    .dma_pending, .aen, .tc, .master_n, .refresh_in_n, .refresh_out_n, .refresh_oe,
    .memr_in_n, .memw_in_n, .ior_in_n, .iow_in_n, .memr_out_n, .memw_out_n,
    .ior_out_n, .iow_out_n, .mem_cmd_oe, .io_cmd_oe, .addr_hi, .smemr_n, .smemw_n,
    .io_reg_rd, .io_reg_wr, .cfg_pins_local, .perf_programmed, .flush_enable,
    .perf_hold, .turbo_or_req_n, .local_req_n, .local_gnt_n, .flush_or_gnt_n, .slow_mode);

  idb_isa_side u_idb_isa_side (.clk_sys, .req_on, .req_ch, .dack_n, .tc, .aen,
    .ior_n(ior_in_n), .iow_n(iow_in_n), .dreq, .io_hits);

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic chk(input logic ok, input string msg);
    checks++;
    if (ok !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic summarize();
    if (fails == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic t_dma(input logic [2:0] ch, input logic [1:0] kind, input logic [15:0] cnt);
    int n;
    int tcs;
    int h;
    int k;
    logic sp;
    n = 0;
    tcs = 0;
    h = io_hits;
    sp = 1'b1;
    req_ch = ch;
    req_on = 1'b1;
    dma_channel = ch;
    dma_kind = kind;
    dma_count = cnt;
    cyc(6);
    chk(dma_pending === 1'b1, "pending");
    dma_start = 1'b1;
    cyc(1);
    dma_start = 1'b0;
    chk(dma_wide === (ch >= 3'd5), "width");
    for (k = 0; k < 400 && dma_busy === 1'b1; k++) begin
      if (sp && !(memr_out_n & memw_out_n))
        n++;
      sp = memr_out_n & memw_out_n;
      if (tc === 1'b1) begin
        tcs++;
        if (kind != 2'd2) chk(n == cnt + 1, "tc early");
      end
      if (dack_n !== 8'hFF) chk(dack_n === ~(8'h01 << ch) && aen === 1'b1, "ack");
      if (dack_n !== 8'hFF) chk(mem_cmd_oe === 1'b1 && io_cmd_oe === 1'b1, "oe");
      if (kind == 2'd0) chk(memr_out_n === iow_out_n && memw_out_n === 1'b1, "rd");
      if (kind == 2'd1) chk(memw_out_n === ior_out_n && memr_out_n === 1'b1, "wr");
      chk(smemr_n === memr_out_n && smemw_n === memw_out_n, "smem dma");
      cyc(1);
    end
    cyc(2);
    chk(k < 400 && tcs > 0 && dack_n === 8'hFF, "dma end");
    if (kind != 2'd2) chk(n == cnt + 1, "count");
    chk(smemr_n === 1'b1 && smemw_n === 1'b1 && io_reg_rd === 1'b0 && io_reg_wr === 1'b0, "echo");
    chk(io_hits == h, "io decode");
    req_on = 1'b0;
    cyc(1);
  endtask

  task automatic t_refused();
    req_ch = 3'd4;
    req_on = 1'b1;
    dma_channel = 3'd4;
    cyc(6);
    dma_start = 1'b1;
    cyc(1);
    dma_start = 1'b0;
    cyc(4);
    chk(dma_busy === 1'b0 && dack_n === 8'hFF && dma_pending === 1'b0, "ch4");
    dma_channel = 3'd1;
    dma_hold_ok = 1'b0;
    dma_start = 1'b1;
    cyc(1);
    dma_start = 1'b0;
    dma_hold_ok = 1'b1;
    cyc(2);
    chk(dma_busy === 1'b0 && dack_n === 8'hFF, "no hold");
    req_on = 1'b0;
  endtask

  task automatic t_strobes();
    for (int a = 0; a < 16; a++) begin
      addr_hi = a[3:0];
      memr_b = 1'b0;
      cyc(6);
      chk(smemr_n === (a != 0), "smemr");
      memr_b = 1'b1;
      memw_b = 1'b0;
      cyc(6);
      chk(smemw_n === (a != 0) && mem_cmd_oe === 1'b0, "smemw");
      memw_b = 1'b1;
    end
    addr_hi = 4'h0;
    ior_b = 1'b0;
    iow_b = 1'b0;
    cyc(6);
    chk(io_reg_rd === 1'b1 && io_reg_wr === 1'b1 && io_cmd_oe === 1'b0, "io");
    refresh_run = 1'b1;
    cyc(4);
    chk(aen === 1'b1 && refresh_out_n === 1'b0 && refresh_oe === 1'b1, "rfsh");
    chk(io_reg_rd === 1'b0, "io in refresh");
    refresh_run = 1'b0;
    ior_b = 1'b1;
    iow_b = 1'b1;
    cyc(4);
    chk(aen === 1'b0 && refresh_oe === 1'b0, "rfsh end");
  endtask

  // bus master on a preferred wide channel
  task automatic t_master();
    req_ch = 3'd5;
    req_on = 1'b1;
    dma_channel = 3'd5;
    dma_kind = IDB_CYC_DMA_READ;
    dma_count = 16'hFFFF;
    cyc(6);
    dma_start = 1'b1;
    cyc(1);
    dma_start = 1'b0;
    cyc(3);
    chk(dack_n === 8'hDF, "master ack");
    master_n = 1'b0;
    cyc(6);
    chk(aen === 1'b0 && mem_cmd_oe === 1'b0 && dack_n === 8'hDF, "master");
    req_on = 1'b0;
    cyc(10);
    master_n = 1'b1;
    cyc(2);
    chk(dma_busy === 1'b0 && dack_n === 8'hFF, "master end");
  endtask

  task automatic t_turbo();
    int w;
    cfg_pins_local = 1'b0;
    turbo_or_req_n = 1'b0;
    cyc(8);
    chk(slow_mode === 1'b0, "unprogrammed");
    perf_programmed = 1'b1;
    cyc(8);
    chk(slow_mode === 1'b1, "slow");
    turbo_or_req_n = 1'b1;
    cyc(8);
    chk(slow_mode === 1'b0, "fast");
    for (int e = 1; e >= 0; e--) begin
      w = 0;
      flush_enable = e[0];
      perf_hold = 1'b1;
      repeat (12) begin
        cyc(1);
        if (flush_or_gnt_n === 1'b0)
          w++;
      end
      chk(w == e * `IDB_FLUSH_CYCLES, "flush");
      perf_hold = 1'b0;
      cyc(4);
    end
  endtask

  task automatic t_local();
    cfg_pins_local = 1'b1;
    turbo_or_req_n = 1'b0;
    cyc(10);
    chk(flush_or_gnt_n === 1'b0 && local_gnt_n === 2'b11, "extra grant");
    turbo_or_req_n = 1'b1;
    local_req_n = 2'b10;
    cyc(10);
    chk(local_gnt_n === 2'b10 && flush_or_gnt_n === 1'b1, "local grant");
    local_req_n = 2'b11;
    cyc(6);
  endtask

  initial begin
    repeat (5) @(negedge clk_sys);
    reset_n = 1'b1;
    cyc(1);
    chk(aen === 1'b0 && tc === 1'b0 && dack_n === 8'hFF, "reset");
    cyc(6);
    t_dma(3'd0, IDB_CYC_DMA_READ, 16'h0000);
    t_dma(3'd3, IDB_CYC_DMA_WRITE, 16'h0002);
    t_dma(3'd5, IDB_CYC_DMA_READ, 16'h0001);
    t_dma(3'd7, IDB_CYC_DMA_WRITE, 16'h0000);
    t_dma(3'd6, IDB_CYC_VERIFY, 16'h0001);
    t_refused();
    t_strobes();
    t_master();
    t_turbo();
    t_local();
    summarize();
  end

  // longest path is well under 3000 cycles
  initial begin
    repeat (20000) @(posedge clk_sys);
    fails++;
    summarize();
  end
endmodule
